/* hdl/maint_ring_pkg.sv */
// How it works
// (RULE_01) supervisory packets lead with one destination word
// (RULE_02) destination word selects internal route, eight values
// (RULE_03) store request type 10 is scan command
// (RULE_04) command byte 63:56, data2 high, data1 low
// (RULE_05) command reply only after scan bus accepts
// (RULE_06) fetch request type 11 reads sixteen words
// (RULE_07) read burst words 0..17 octal, MSB byte first
// (RULE_08) one fetch reply per fetch request
// (RULE_09) store request type 11 carries sixteen words
// (RULE_10) requester packs write burst MSB byte first
// (RULE_11) data reply only after scan bus accepts
// (RULE_12) requester keeps one scan write outstanding
// (RULE_13) delta flag: 0 normal, 1 delta addressing
// (RULE_14) corrupt and error flags: 1 means bad
// (RULE_15) block length six bits, 1 to 32
// (RULE_16) master address echoed into block read reply
// (RULE_17) read reply holds data or error flag; a memory fault on block read returns a zero word with the flag clear
// (RULE_18) block write stores 1..32 words to memory
// (RULE_19) write reply means received, may flag error
// (RULE_20) scan packets carry boundary scan commands
// (RULE_21) don't-care bits ignored, driven zero in replies
package maint_ring_pkg;
  // ====
  // destinations of the leading header word
  localparam logic [2:0] DEST_STORE_REQ = 3'h0;
  localparam logic [2:0] DEST_FETCH_RSP = 3'h1;
  localparam logic [2:0] DEST_BLK_DONE  = 3'h2;
  localparam logic [2:0] DEST_MSG       = 3'h3;
  localparam logic [2:0] DEST_FETCH_REQ = 3'h4;
  localparam logic [2:0] DEST_INIT_RSP  = 3'h5;
  localparam logic [2:0] DEST_SCAN      = 3'h6;
  localparam logic [2:0] DEST_RING_OUT  = 3'h7;
  // ====
  // header word 1 field positions
  localparam int CMD_LSB     = 56;
  localparam int TYPE_LSB    = 16;
  localparam int OP_LSB      = 12;
  localparam int DELTA_BIT   = 11;
  localparam int CORRUPT_BIT = 10;
  localparam int ERROR_BIT   = 9;
  localparam int LEN_LSB     = 0;
  localparam logic [1:0] TYPE_CMD  = 2'h2;
  localparam logic [1:0] TYPE_DATA = 2'h3;
  localparam logic [3:0] OP_SVC_STORE     = 4'h1;
  localparam logic [3:0] OP_SVC_FETCH     = 4'h2;
  localparam logic [3:0] OP_SVC_STORE_RPL = 4'h3;
  localparam logic [3:0] OP_SVC_FETCH_RPL = 4'h4;
  localparam logic [3:0] OP_BLK_READ      = 4'h5;
  localparam logic [3:0] OP_BLK_FETCH_RPL = 4'h6;
  localparam logic [3:0] OP_BLK_WRITE     = 4'h7;
  localparam logic [3:0] OP_BLK_STORE_RPL = 4'h8;
  localparam logic [5:0] SCAN_WORDS = 6'h10;
  localparam int         MAX_LEN    = 32;
  // scan bus operations
  localparam logic [1:0] SCAN_OP_CMD = 2'h0;
  localparam logic [1:0] SCAN_OP_WR  = 2'h1;
  localparam logic [1:0] SCAN_OP_RD  = 2'h2;
  // ====
  // requester APB registers
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_MADDR  = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_IDX    = 8'h0c;
  localparam logic [7:0] REG_BUF_LO = 8'h10;
  localparam logic [7:0] REG_BUF_HI = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [2:0] KIND_CMD    = 3'h0;
  localparam logic [2:0] KIND_SSTORE = 3'h1;
  localparam logic [2:0] KIND_SFETCH = 3'h2;
  localparam logic [2:0] KIND_BREAD  = 3'h3;
  localparam logic [2:0] KIND_BWRITE = 3'h4;

  // header word 1 with every unused bit zero
  function automatic logic [63:0] mk_hdr1(input logic [3:0] op, input logic [1:0] typ,
                                          input logic delta, input logic err,
                                          input logic [5:0] len, input logic [7:0] cmd);
    logic [63:0] h;
    h = 64'h0;
    h[CMD_LSB +: 8]  = cmd;
    h[TYPE_LSB +: 2] = typ;
    h[OP_LSB +: 4]   = op;
    h[DELTA_BIT]     = delta;
    h[ERROR_BIT]     = err;
    h[LEN_LSB +: 6]  = len;
    return h;
  endfunction
endpackage

/* hdl/ring_link.sv */
`timescale 1ns/1ps
// ====
// word stream each way between requester and device
interface ring_link;
  logic [63:0] reqWord;
  logic        reqValid;
  logic        reqLast;
  logic        reqReady;
  logic [63:0] rspWord;
  logic        rspValid;
  logic        rspLast;
  logic        rspReady;
  modport device (input reqWord, reqValid, reqLast, rspReady,
                  output reqReady, rspWord, rspValid, rspLast);
  modport requester (output reqWord, reqValid, reqLast, rspReady,
                     input reqReady, rspWord, rspValid, rspLast);
endinterface

/* hdl/maint_ring_device.sv */
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module maint_ring_device
  import maint_ring_pkg::*;
#(
  parameter int LEN_MAX = MAX_LEN
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  ring_link.device         link,
  output logic             scanReq,
  output logic [1:0]       scanOp,
  output logic [7:0]       scanCmd,
  output logic [63:0]      scanWord,
  input  wire logic        scanAck,
  input  wire logic [63:0] scanRdWord,
  output logic             memReq,
  output logic             memWe,
  output logic [31:0]      memAddr,
  output logic [63:0]      memWdata,
  input  wire logic        memAck,
  input  wire logic [63:0] memRdata,
  input  wire logic        memErr
);
  typedef enum {ST_DEST, ST_H1, ST_H2, ST_PAY, ST_SCAN, ST_MEM, ST_FETCH,
                ST_TX, ST_DRAIN} state_e;
  localparam logic [1:0] TX_DEST = 2'h0;
  localparam logic [1:0] TX_H1   = 2'h1;
  localparam logic [1:0] TX_H2   = 2'h2;
  localparam logic [1:0] TX_DATA = 2'h3;

  state_e      state_q;
  logic [2:0]  dest_q;
  logic [63:0] h1_q;
  logic [63:0] addr_q;
  logic [63:0] data_q;
  logic [5:0]  idx_q;
  logic [1:0]  txSel_q;
  logic        err_q;
  logic        reply_q;

  // ====
  // packet decode
  wire logic       acc      = link.reqValid && link.reqReady;
  wire logic [1:0] typ      = h1_q[TYPE_LSB +: 2];
  wire logic [3:0] op       = h1_q[OP_LSB +: 4];
  wire logic [5:0] len      = h1_q[LEN_LSB +: 6];
  wire logic       isScan   = dest_q == DEST_SCAN; // RULE_02
  wire logic       isCmd    = isScan && op == OP_SVC_STORE && typ == TYPE_CMD; // RULE_03
  wire logic       isScanWr = isScan && op == OP_SVC_STORE && typ == TYPE_DATA; // RULE_09
  wire logic       isScanRd = isScan && op == OP_SVC_FETCH && typ == TYPE_DATA; // RULE_06
  wire logic       isBlkRd  = dest_q == DEST_FETCH_REQ && op == OP_BLK_READ;  // RULE_02
  wire logic       isBlkWr  = dest_q == DEST_STORE_REQ && op == OP_BLK_WRITE; // RULE_02
  wire logic       isBlk    = isBlkRd || isBlkWr;
  wire logic       isWrFlow = isCmd || isScanWr || isBlkWr;
  wire logic       isRdFlow = isScanRd || isBlkRd;
  // block length outside 1..32 is an error
  wire logic       lenOk    = len != 6'h0 && len <= 6'(LEN_MAX); // RULE_15
  wire logic       badReq   = h1_q[CORRUPT_BIT] || (isBlk && !lenOk);  // RULE_14
  wire logic [5:0] words    = isCmd ? 6'h1 : (isBlk ? len : SCAN_WORDS);
  wire logic       lastIdx  = idx_q == words - 6'h1;
  wire logic       hasData  = isRdFlow && !err_q; // RULE_17

  // ====
  // reply header, unused bits zero
  wire logic [3:0] rplOp  = isBlkRd ? OP_BLK_FETCH_RPL : isBlkWr ? OP_BLK_STORE_RPL :
                            isScanRd ? OP_SVC_FETCH_RPL : OP_SVC_STORE_RPL;
  wire logic [5:0] rplLen = isBlk ? len : (isScanRd ? SCAN_WORDS : 6'h0);
  wire logic [63:0] rplH1 = mk_hdr1(rplOp, typ, h1_q[DELTA_BIT], err_q,
                                    rplLen, 8'h00); // RULE_21 RULE_13
  wire logic [63:0] txWord = (txSel_q == TX_DEST) ? {61'h0, DEST_RING_OUT} :
                             (txSel_q == TX_H1) ? rplH1 :
                             (txSel_q == TX_H2) ? addr_q : data_q;     // RULE_16 RULE_07
  wire logic        txLast = (txSel_q == TX_H2 && !hasData) ||
                             (txSel_q == TX_DATA && lastIdx);
  wire logic [31:0] wordAddr = addr_q[31:0] + {26'h0, idx_q};

  // ====
  // receive, then act and reply; reads send the reply header before the first fetch
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q       <= ST_DEST;
      dest_q        <= 3'h0;
      h1_q          <= 64'h0;
      addr_q        <= 64'h0;
      data_q        <= 64'h0;
      idx_q         <= 6'h0;
      txSel_q       <= TX_DEST;
      err_q         <= 1'b0;
      reply_q       <= 1'b0;
      link.reqReady <= 1'b0;
      link.rspWord  <= 64'h0;
      link.rspValid <= 1'b0;
      link.rspLast  <= 1'b0;
      scanReq       <= 1'b0;
      scanOp        <= SCAN_OP_CMD;
      scanCmd       <= 8'h00;
      scanWord      <= 64'h0;
      memReq        <= 1'b0;
      memWe         <= 1'b0;
      memAddr       <= 32'h0;
      memWdata      <= 64'h0;
    end else begin
      case (state_q)
        ST_DEST: begin
          link.reqReady <= 1'b1;
          if (acc) begin
            dest_q  <= link.reqWord[2:0]; // RULE_01
            state_q <= ST_H1;
          end
        end
        ST_H1: begin
          if (acc) begin
            h1_q    <= link.reqWord;
            state_q <= ST_H2;
          end
        end
        ST_H2: begin
          if (acc) begin
            addr_q  <= link.reqWord;
            idx_q   <= 6'h0;
            txSel_q <= TX_DEST;
            err_q   <= badReq;
            reply_q <= isWrFlow || isRdFlow;
            if (isWrFlow && !badReq) begin
              state_q <= ST_PAY;
            end else if (isWrFlow) begin
              state_q <= ST_DRAIN; // RULE_19
            end else if (isRdFlow) begin
              link.reqReady <= 1'b0;
              state_q       <= ST_TX; // RULE_08
            end else if (link.reqLast) begin
              state_q <= ST_DEST;
            end else begin
              state_q <= ST_DRAIN;
            end
          end
        end
        ST_PAY: begin
          if (acc) begin
            link.reqReady <= 1'b0;
            if (isBlkWr) begin
              memReq   <= 1'b1; // RULE_18
              memWe    <= 1'b1;
              memAddr  <= wordAddr;
              memWdata <= link.reqWord;
              state_q  <= ST_MEM;
            end else begin
              scanReq  <= 1'b1; // RULE_20
              scanOp   <= isCmd ? SCAN_OP_CMD : SCAN_OP_WR;
              scanCmd  <= isCmd ? h1_q[CMD_LSB +: 8] : 8'h00;          // RULE_04
              scanWord <= link.reqWord; // RULE_04 RULE_09
              state_q  <= ST_SCAN;
            end
          end
        end
        ST_FETCH: begin
          if (isBlkRd) begin
            memReq  <= 1'b1;
            memWe   <= 1'b0;
            memAddr <= wordAddr;
            state_q <= ST_MEM;
          end else begin
            scanReq <= 1'b1;
            scanOp  <= SCAN_OP_RD; // RULE_06
            scanCmd <= 8'h00;
            state_q <= ST_SCAN;
          end
        end
        ST_SCAN, ST_MEM: begin
          if ((state_q == ST_SCAN && scanAck) || (state_q == ST_MEM && memAck)) begin
            scanReq <= 1'b0;
            memReq  <= 1'b0;
            if (isRdFlow) begin
              data_q  <= (state_q == ST_SCAN) ? scanRdWord : (memErr ? 64'h0 : memRdata);
              txSel_q <= TX_DATA;
              state_q <= ST_TX;
            end else begin
              err_q <= err_q || (state_q == ST_MEM && memErr);
              if (lastIdx) begin
                state_q <= ST_TX; // RULE_05 RULE_11
              end else begin
                idx_q         <= idx_q + 6'h1;
                link.reqReady <= 1'b1;
                state_q       <= ST_PAY;
              end
            end
          end
        end
        ST_TX: begin
          if (!link.rspValid) begin
            link.rspWord  <= txWord;
            link.rspLast  <= txLast;
            link.rspValid <= 1'b1;
          end else if (link.rspReady) begin
            link.rspValid <= 1'b0;
            link.rspLast  <= 1'b0;
            if (link.rspLast) begin
              state_q <= ST_DEST;
            end else if (txSel_q == TX_H2) begin
              state_q <= ST_FETCH;
            end else if (txSel_q == TX_DATA) begin
              idx_q   <= idx_q + 6'h1; // RULE_07
              state_q <= ST_FETCH;
            end else begin
              txSel_q <= txSel_q + 2'h1;
            end
          end
        end
        ST_DRAIN: begin
          link.reqReady <= 1'b1;
          if (acc && link.reqLast) begin
            link.reqReady <= 1'b0;
            state_q       <= reply_q ? ST_TX : ST_DEST;
          end
        end
        default: begin
          state_q <= ST_DEST;
        end
      endcase
    end
  end
endmodule // maint_ring_device

/* hdl/maint_ring_requester.sv */
`timescale 1ns/1ps
module maint_ring_requester
  import maint_ring_pkg::*;
#(
  parameter int BUF_DEPTH = MAX_LEN
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  ring_link.requester      link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  typedef enum {HS_IDLE, HS_TX, HS_RX} hstate_e;

  hstate_e     state_q;
  logic [63:0] dataMem_q [BUF_DEPTH];
  logic [31:0] ctrl_q;
  logic [31:0] maddr_q;
  logic [31:0] addr_q;
  logic [4:0]  idx_q;
  logic [5:0]  cnt_q;
  logic        done_q;
  logic        err_q;
  logic [5:0]  rlen_q;

  // ====
  // register decode and request header
  wire logic       setup  = psel && !penable;
  wire logic       wrAcc  = psel && penable && pready && pwrite;
  wire logic       mapped = paddr <= REG_STATUS && paddr[1:0] == 2'h0;
  wire logic [2:0] kind   = ctrl_q[3:1];
  wire logic [5:0] len    = ctrl_q[17:12];
  wire logic       start  = wrAcc && paddr == REG_CTRL && pwdata[0] && state_q == HS_IDLE; // RULE_12
  wire logic       isScn  = kind <= KIND_SFETCH;
  wire logic [3:0] op     = (kind == KIND_SFETCH) ? OP_SVC_FETCH : (kind == KIND_BREAD) ?
                            OP_BLK_READ : (kind == KIND_BWRITE) ? OP_BLK_WRITE : OP_SVC_STORE;
  wire logic [2:0] dest   = isScn ? DEST_SCAN : (kind == KIND_BREAD) ? DEST_FETCH_REQ :
                            DEST_STORE_REQ;
  wire logic [5:0] nPay   = (kind == KIND_CMD) ? 6'h1 : (kind == KIND_SSTORE) ? SCAN_WORDS :
                            (kind == KIND_BWRITE) ? len : 6'h0;
  wire logic [63:0] hdr1  = mk_hdr1(op, (kind == KIND_CMD) ? TYPE_CMD : (isScn ? TYPE_DATA : 2'h0),
                                    ctrl_q[18], 1'b0, isScn ? 6'h0 : len, ctrl_q[11:4]); // RULE_03 RULE_13
  wire logic [63:0] txWord = (cnt_q == 6'h0) ? {61'h0, dest} :       // RULE_01
                             (cnt_q == 6'h1) ? hdr1 :
                             (cnt_q == 6'h2) ? {maddr_q, addr_q} :
                             dataMem_q[5'(cnt_q - 6'h3)]; // RULE_10
  wire logic        txLast = cnt_q == nPay + 6'h2;
  wire logic [5:0]  rxIdx  = cnt_q - 6'h3;
  wire logic [31:0] rdMux  = (paddr == REG_CTRL) ? ctrl_q : (paddr == REG_MADDR) ? maddr_q :
                             (paddr == REG_ADDR) ? addr_q : (paddr == REG_IDX) ? {27'h0, idx_q} :
                             (paddr == REG_BUF_LO) ? dataMem_q[idx_q][31:0] :
                             (paddr == REG_BUF_HI) ? dataMem_q[idx_q][63:32] :
                             (paddr == REG_STATUS) ? {18'h0, rlen_q, 5'h0, err_q, done_q,
                                                      state_q != HS_IDLE} : 32'h0;

  // =========================================================
  // apb slave: answer in the first access cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      ctrl_q  <= 32'h0;
      maddr_q <= 32'h0;
      addr_q  <= 32'h0;
      idx_q   <= 5'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= setup && !pwrite ? rdMux : 32'h0;
      if (wrAcc && state_q == HS_IDLE) begin
        if (paddr == REG_CTRL) ctrl_q <= {13'h0, pwdata[18:1], 1'b0};
        if (paddr == REG_MADDR) maddr_q <= pwdata;
        if (paddr == REG_ADDR) addr_q <= pwdata;
      end
      if (wrAcc && paddr == REG_IDX) idx_q <= pwdata[4:0];
    end
  end

  // payload buffer, written by software or by a reply
  always_ff @(posedge core_clk) begin
    if (wrAcc && state_q == HS_IDLE && paddr == REG_BUF_LO) dataMem_q[idx_q][31:0] <= pwdata;
    if (wrAcc && state_q == HS_IDLE && paddr == REG_BUF_HI) dataMem_q[idx_q][63:32] <= pwdata;
    if (state_q == HS_RX && link.rspValid && link.rspReady && cnt_q >= 6'h3 &&
        rxIdx < 6'(BUF_DEPTH)) begin
      dataMem_q[5'(rxIdx)] <= link.rspWord; // RULE_07
    end
  end

  // ====
  // send one request, then wait for its reply
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q       <= HS_IDLE;
      cnt_q         <= 6'h0;
      done_q        <= 1'b0;
      err_q         <= 1'b0;
      rlen_q        <= 6'h0;
      link.reqWord  <= 64'h0;
      link.reqValid <= 1'b0;
      link.reqLast  <= 1'b0;
      link.rspReady <= 1'b0;
    end else begin
      case (state_q)
        HS_IDLE: begin
          cnt_q <= 6'h0;
          if (start) begin
            done_q  <= 1'b0;
            state_q <= HS_TX;
          end
        end
        HS_TX: begin
          if (!link.reqValid) begin
            link.reqWord  <= txWord;
            link.reqLast  <= txLast;
            link.reqValid <= 1'b1;
          end else if (link.reqReady) begin
            link.reqValid <= 1'b0;
            link.reqLast  <= 1'b0;
            cnt_q         <= link.reqLast ? 6'h0 : cnt_q + 6'h1;
            if (link.reqLast) begin
              link.rspReady <= 1'b1;
              state_q       <= HS_RX; // RULE_12
            end
          end
        end
        HS_RX: begin
          if (link.rspValid) begin
            cnt_q <= cnt_q + 6'h1;
            if (cnt_q == 6'h1) begin
              err_q  <= link.rspWord[ERROR_BIT] || link.rspWord[CORRUPT_BIT]; // RULE_14
              rlen_q <= link.rspWord[LEN_LSB +: 6];
            end
            if (link.rspLast) begin
              link.rspReady <= 1'b0;
              done_q        <= 1'b1;
              state_q       <= HS_IDLE;
            end
          end
        end
        default: begin
          state_q <= HS_IDLE;
        end
      endcase
    end
  end
endmodule // maint_ring_requester

/* tb/maint_ring_sva.sv */
`timescale 1ns/1ps
// ====
// link and bus checks
module maint_ring_sva
  import maint_ring_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [63:0] reqWord,
  input wire logic        reqValid,
  input wire logic        reqLast,
  input wire logic        reqReady,
  input wire logic [63:0] rspWord,
  input wire logic        rspValid,
  input wire logic        rspLast,
  input wire logic        rspReady,
  input wire logic        scanReq,
  input wire logic [1:0]  scanOp,
  input wire logic [63:0] scanWord,
  input wire logic        scanAck,
  input wire logic        memReq,
  input wire logic [31:0] memAddr,
  input wire logic [63:0] memWdata,
  input wire logic        memAck
);
  logic rspFirst_q;

  // marks the leading word of each reply packet
  always_ff @(posedge core_clk) begin
    if (!rst_n) rspFirst_q <= 1'b1;
    else if (rspValid && rspReady) rspFirst_q <= rspLast;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ====
  // handshakes, routing and reply timing
  a_req_held: assert property (
    reqValid && !reqReady |=> reqValid && $stable(reqWord) && $stable(reqLast))
    else $error("request not held");
  a_rsp_held: assert property (
    rspValid && !rspReady |=> rspValid && $stable(rspWord) && $stable(rspLast))
    else $error("reply not held");
  a_rsp_dest: assert property (rspValid && rspFirst_q |-> rspWord[2:0] == DEST_RING_OUT)
    else $error("wrong reply destination");
  a_one_outstanding: assert property (rspValid |-> !reqValid)
    else $error("request during reply");
  a_reply_after_scan: assert property (scanReq && scanOp != SCAN_OP_RD |-> !rspValid)
    else $error("early reply");
  a_cmd_reply_soon: assert property (
    scanAck && scanOp == SCAN_OP_CMD |-> ##[1:3] rspValid)
    else $error("no command reply");
  a_scan_drop: assert property (scanAck |=> !scanReq)
    else $error("scan request not dropped");
  a_scan_held: assert property (
    scanReq && !scanAck |=> scanReq && $stable(scanOp) && $stable(scanWord))
    else $error("scan request not held");
  a_mem_held: assert property (
    memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWdata))
    else $error("memory request not held");
endmodule // maint_ring_sva

/* tb/tb.sv */
`timescale 1ns/1ps
// ====
// bench: requester over APB, scan and memory models
module tb;
  import maint_ring_pkg::*;
  typedef struct packed {logic [2:0] kind; logic [5:0] len; logic [7:0] cmd; logic [7:0] addr;
    logic err;} row_s;
  localparam row_s ROWS [9] = '{'{KIND_CMD, 6'h00, 8'h3c, 8'h00, 1'b0},
    '{KIND_SSTORE, 6'h10, 8'h00, 8'h00, 1'b0}, '{KIND_SFETCH, 6'h10, 8'h00, 8'h00, 1'b0},
    '{KIND_BWRITE, 6'h20, 8'h00, 8'h00, 1'b0}, '{KIND_BREAD, 6'h20, 8'h00, 8'h00, 1'b0},
    '{KIND_BWRITE, 6'h01, 8'h00, 8'h28, 1'b0}, '{KIND_BREAD, 6'h01, 8'h00, 8'h28, 1'b0},
    '{KIND_BREAD, 6'h00, 8'h00, 8'h00, 1'b1}, '{KIND_BWRITE, 6'h21, 8'h00, 8'h00, 1'b1}};
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, scanReq, memReq, memWe;
  logic        scanAck = 1'b0, memAck = 1'b0, memErr = 1'b0;
  logic [1:0]  scanOp;
  logic [7:0]  paddr, scanCmd;
  logic [31:0] pwdata, prdata, memAddr, errAddr;
  logic [63:0] scanWord, memWdata, scanRdWord = 64'h0, memRdata = 64'h0;
  logic [63:0] mem [64];
  logic [63:0] reqLog [$], rspLog [$], wordLog [$];
  logic [9:0]  opLog [$];
  int          slow, waitCnt, rdCnt, rspPkts, failCount, cmpCount;

  // 100 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ring_link link ();
  maint_ring_requester u_maint_ring_requester (.core_clk, .rst_n, .link(link), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  maint_ring_device u_maint_ring_device (.core_clk, .rst_n, .link(link), .scanReq, .scanOp, .scanCmd,
    .scanWord, .scanAck, .scanRdWord, .memReq, .memWe, .memAddr, .memWdata, .memAck, .memRdata,
    .memErr);
  maint_ring_sva u_maint_ring_sva (.core_clk, .rst_n, .reqWord(link.reqWord),
    .reqValid(link.reqValid), .reqLast(link.reqLast), .reqReady(link.reqReady),
    .rspWord(link.rspWord), .rspValid(link.rspValid), .rspLast(link.rspLast),
    .rspReady(link.rspReady), .scanReq, .scanOp, .scanWord, .scanAck, .memReq, .memAddr,
    .memWdata, .memAck);

  // scan and memory models, settable stall
  always @(posedge core_clk) begin
    scanAck <= 1'b0;
    memAck  <= 1'b0;
    waitCnt <= (scanReq || memReq) ? waitCnt + 1 : 0;
    if (scanReq && !scanAck && waitCnt >= slow) begin
      scanAck    <= 1'b1;
      scanRdWord <= {32'hfeed0000, rdCnt};
      waitCnt    <= 0;
      opLog.push_back({scanOp, scanCmd});
      wordLog.push_back(scanWord);
      if (scanOp == SCAN_OP_RD) rdCnt <= rdCnt + 1;
    end
    if (memReq && !memAck && waitCnt >= slow) begin
      memAck   <= 1'b1;
      memErr   <= memAddr == errAddr;
      memRdata <= mem[memAddr[5:0]];
      waitCnt  <= 0;
      if (memWe) mem[memAddr[5:0]] <= memWdata;
    end
  end

  // log every word taken on the link each way
  always @(posedge core_clk) begin
    if (link.reqValid && link.reqReady) reqLog.push_back(link.reqWord);
    if (link.rspValid && link.rspReady) rspLog.push_back(link.rspWord);
    if (link.rspValid && link.rspReady && link.rspLast) rspPkts++;
  end

  // ====
  // helpers
  function automatic logic [63:0] pat(input int i, input int s);
    return {16'hbeef, s[15:0], 24'h0, i[7:0]};
  endfunction

  task automatic check(input string what, input logic [71:0] exp, input logic [71:0] got);
    cmpCount++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one APB transfer, bounded wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1 && ++n < 20);
    if (pready !== 1'b1) begin
      check("bus answer", 1, pready);
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  task automatic getw(input int i, output logic [63:0] w);
    wr(REG_IDX, i);
    rd(REG_BUF_LO, w[31:0]);
    rd(REG_BUF_HI, w[63:32]);
  endtask

  // start one transfer and wait for done
  task automatic run(input row_s r, input logic dl, input int seed, output logic [31:0] s);
    int n;
    n = 0;
    for (int i = 0; i < 32; i++) begin
      wr(REG_IDX, i);
      wr(REG_BUF_LO, pat(i, seed));
      wr(REG_BUF_HI, pat(i, seed) >> 32);
    end
    reqLog.delete();
    rspLog.delete();
    opLog.delete();
    wordLog.delete();
    rdCnt   = 0;
    rspPkts = 0;
    wr(REG_MADDR, {24'hcafe00, 5'h0, r.kind});
    wr(REG_ADDR, {24'h0, r.addr});
    wr(REG_CTRL, {13'h0, dl, r.len, r.cmd, r.kind, 1'b1});
    do rd(REG_STATUS, s); while (s[1] !== 1'b1 && ++n < 400);
    if (s[1] !== 1'b1) begin
      check("done flag", 1, s[1]);
      summarize();
    end
  endtask

  // ====
  // main sequence
  initial begin
    logic [31:0] s, q;
    logic        e;
    logic [63:0] w;
    logic [2:0]  dst;
    row_s        rw;
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {slow, waitCnt, rdCnt, rspPkts, failCount, cmpCount} = '0;
    errAddr = '1;
    for (int i = 0; i < 64; i++) mem[i] = {32'h0, i};
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(REG_STATUS, s);
    check("status after reset", 0, s);
    $display("test reset done");
    for (int r = 0; r < 9; r++) begin
      rw   = ROWS[r];
      slow = r % 3;
      run(rw, r[0], r, s);
      dst = rw.kind == KIND_BREAD ? DEST_FETCH_REQ : rw.kind == KIND_BWRITE ? DEST_STORE_REQ : DEST_SCAN;
      check("request dest", dst, reqLog[0][2:0]);
      check("request delta", r[0], reqLog[1][DELTA_BIT]);
      check("reply error", rw.err, s[2]);
      check("reply count", 1, rspPkts);
      check("address echo", reqLog[2], rspLog[2]);
      if (rw.kind <= KIND_SFETCH)
        check("scan type", rw.kind == KIND_CMD ? TYPE_CMD : TYPE_DATA, reqLog[1][17:16]);
      case (rw.kind)
        KIND_CMD: begin
          check("scan command", {SCAN_OP_CMD, rw.cmd}, opLog[0]);
          check("command data", pat(0, r), wordLog[0]);
        end
        KIND_SSTORE: begin
          check("scan writes", 16, wordLog.size());
          for (int i = 0; i < 16; i++)
            check("scan write", {SCAN_OP_WR, pat(i, r)}, {opLog[i][9:8], wordLog[i]});
        end
        KIND_SFETCH: begin
          check("fetch length", SCAN_WORDS, s[13:8]);
          for (int i = 0; i < 16; i++) begin
            getw(i, w);
            check("fetch data", {32'hfeed0000, i}, w);
          end
        end
        default: if (!rw.err) begin
          if (rw.kind == KIND_BREAD) check("read length", rw.len, s[13:8]);
          for (int i = 0; i < rw.len; i++) begin
            if (rw.kind == KIND_BWRITE) check("memory word", pat(i, r), mem[rw.addr + i]);
            else getw(i, w);
            if (rw.kind == KIND_BREAD) check("read word", mem[rw.addr + i], w);
          end
        end
      endcase
      $display("test row %0d done", r);
    end
    // memory fault during a block write comes back as a reply error
    errAddr = 32'd49;
    rw = '{KIND_BWRITE, 6'h02, 8'h00, 8'h30, 1'b1};
    run(rw, 1'b0, 9, s);
    check("write fault", 1, s[2]);
    errAddr = '1;
    $display("test fault done");
    // unmapped and unaligned places are refused
    apb(1'b0, 8'h1c, 32'h0, q, e);
    check("unmapped", {1'b1, 32'h0}, {e, q});
    apb(1'b0, 8'h02, 32'h0, q, e);
    check("unaligned", {1'b1, 32'h0}, {e, q});
    $display("test refusal done");
    summarize();
  end
endmodule // tb
